// ===== hdl/ifph_pkg.sv
// Constants and carrier types for the attenuation telecommand handler.
// Assumes a 20 MHz instrument clock and 16-bit telecommand words.
package ifph_pkg;

	// Clock and timing.
	localparam int CLK_PERIOD_NS = 50;
	localparam int PON_DELAY_NS  = 1000;
	localparam int PON_CYC_INT   = (PON_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] PON_CYC = 8'(PON_CYC_INT);

	// Expected packet words; the packet is seven 16-bit words.
	localparam logic [2:0]  LAST_IDX      = 3'h6;
	localparam logic [15:0] HDR_WORD0     = 16'h1C7C;
	localparam logic [15:0] SEQ_MASK      = 16'hF800;
	localparam logic [15:0] SEQ_WORD1     = 16'hC000;
	localparam logic [15:0] LEN_WORD2     = 16'h0007;
	localparam logic [15:0] DFH_WORD3     = 16'h11C0;
	localparam logic [15:0] SUB_WORD4     = 16'h0400;
	localparam logic [15:0] DATA_HI_MASK  = 16'hFFF0;
	localparam logic [15:0] CRC_INIT      = 16'hFFFF;
	localparam logic [15:0] CRC_POLY      = 16'h1021;

	// Attenuation setting and control word layout.
	localparam logic [3:0]  HELD_RESET    = 4'h3;
	localparam logic [11:0] CTRL_WORD_LOC = 12'h2BC;
	localparam int CW_B0 = 6;
	localparam int CW_B1 = 7;
	localparam int CW_B2 = 13;
	localparam int CW_B3 = 14;
	localparam int RB_B0 = 9;
	localparam int RB_B1 = 8;
	localparam int RB_B2 = 2;
	localparam int RB_B3 = 1;

	// Wishbone register byte offsets.
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CWORD  = 8'h08;
	localparam logic [7:0] REG_RBACK  = 8'h0C;
	localparam logic [7:0] REG_COUNT  = 8'h10;
	localparam int CTRL_PWR_BIT = 0;

	typedef struct packed {
		logic        valid;
		logic        last;
		logic [15:0] data;
	} ifph_tc_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} ifph_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} ifph_wb_rsp_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SHUT  = 2'b01,
		ST_APPLY = 2'b11,
		ST_CAL   = 2'b10
	} ifph_state_t;

endpackage

// ===== hdl/ifph_crc16.sv
// Running 16-bit error-control checksum over telecommand words.
// Assumes the caller clears it after each packet's final word.
`timescale 1ns/1ns
`default_nettype none
module ifph_crc16 (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        clear_i,
	input  wire logic        en_i,
	input  wire logic [15:0] data_i,
	output logic      [15:0] crc_o
);
	import ifph_pkg::*;

	logic [15:0] crc_q;
	logic [15:0] crc_d;

	// One word folds in MSB first; clear has priority so a new packet starts clean.
	always_comb begin
		logic [15:0] c;
		c = crc_q;
		for (int i = 15; i >= 0; i--) begin
			if (c[15] ^ data_i[i]) begin
				c = {c[14:0], 1'b0} ^ CRC_POLY;
			end else begin
				c = {c[14:0], 1'b0};
			end
		end
		crc_d = crc_q;
		if (clear_i) begin
			crc_d = CRC_INIT;
		end else if (en_i) begin
			crc_d = c;
		end
	end

	// Register stage.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			crc_q <= CRC_INIT;
		end else begin
			crc_q <= crc_d;
		end
	end

	assign crc_o = crc_q;
endmodule
`default_nettype wire

// ===== hdl/ifph_handler.sv
// Attenuation telecommand handler: checks packets, holds the setting, drives the four control bits.
// Assumes a telecommand word stream, a shutdown handshake from the executive, and a Wishbone master.
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module ifph_handler #(
	parameter logic [7:0] PON_CYCLES = ifph_pkg::PON_CYC
) (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire ifph_pkg::ifph_tc_t     tc_i,
	output logic                        tc_ready_o,
	input  wire logic                   shutdown_done_i,
	output logic                        shutdown_req_o,
	output logic                        cal_start_o,
	output logic                        accept_o,
	output logic                        reject_o,
	output logic [3:0]                  atten_o,
	output logic [15:0]                 ctrl_word_o,
	output logic [15:0]                 readback_o,
	input  wire ifph_pkg::ifph_wb_req_t wb_i,
	output var ifph_pkg::ifph_wb_rsp_t  wb_o
);
	import ifph_pkg::*;

	ifph_state_t state_q, state_d;
	logic [2:0]  idx_q, idx_d;
	logic        bad_q, bad_d;
	logic [3:0]  val_q, val_d;
	logic [3:0]  held_q, held_d;
	logic [3:0]  out_q, out_d;
	logic        pwr_q, pwr_d;
	logic [7:0]  pon_q, pon_d;
	logic        cal_q, cal_d;
	logic        acc_q, acc_d;
	logic        rej_q, rej_d;
	logic [7:0]  nacc_q, nacc_d;
	logic [7:0]  nrej_q, nrej_d;
	logic        ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic        take;
	logic        word_ok;
	logic        good;
	logic        pon_fire;
	logic        wb_req;
	logic        wr_ctrl;
	logic [15:0] crc;

	// Checksum runs over every word but the last; the last word is compared against it.
	ifph_crc16 u_crc (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.clear_i (take && tc_i.last),
		.en_i    (take && !tc_i.last),
		.data_i  (tc_i.data),
		.crc_o   (crc)
	);

	// Words are refused while a mode change runs, so a second command cannot race the first.
	assign tc_ready_o = (state_q == ST_IDLE);
	assign take       = tc_i.valid && tc_ready_o;

	// Per-word field check against the fixed packet image.
	always_comb begin
		case (idx_q)
			3'h0:    word_ok = (tc_i.data == HDR_WORD0);
			3'h1:    word_ok = ((tc_i.data & SEQ_MASK) == SEQ_WORD1);
			3'h2:    word_ok = (tc_i.data == LEN_WORD2);
			3'h3:    word_ok = (tc_i.data == DFH_WORD3);
			3'h4:    word_ok = (tc_i.data == SUB_WORD4);
			3'h5:    word_ok = ((tc_i.data & DATA_HI_MASK) == 16'h0000);
			3'h6:    word_ok = (tc_i.data == crc);
			default: word_ok = 1'b0;
		endcase
	end

	assign good = take && tc_i.last && !bad_q && word_ok && (idx_q == LAST_IDX);

	// Packet parser; a short, long or mismatching packet is dropped at its last word.
	always_comb begin
		idx_d = idx_q;
		bad_d = bad_q;
		val_d = val_q;
		acc_d = 1'b0;
		rej_d = 1'b0;
		if (take) begin
			if (tc_i.last) begin
				idx_d = 3'h0;
				bad_d = 1'b0;
				acc_d = good;
				rej_d = !good;
			end else begin
				if (!word_ok) begin
					bad_d = 1'b1;
				end
				if (idx_q == 3'h5) begin
					val_d = tc_i.data[3:0];
				end
				if (idx_q != 3'h7) begin
					idx_d = idx_q + 3'h1;
				end
			end
		end
	end

	assign pon_fire = pwr_q && (pon_q == 8'h01);

	// Held setting, mode change sequencer and output bits.
	always_comb begin
		state_d = state_q;
		held_d  = held_q;
		out_d   = out_q;
		cal_d   = 1'b0;
		pon_d   = pon_q;
		if (good) begin
			held_d = val_q;
			if (pwr_q) begin
				state_d = ST_SHUT;
			end else begin
				cal_d = 1'b1;
			end
		end
		case (state_q)
			ST_IDLE: begin
			end
			ST_SHUT: begin
				if (shutdown_done_i) begin
					state_d = ST_APPLY;
				end
			end
			ST_APPLY: begin
				if (pwr_q) begin
					out_d = held_q;
				end
				state_d = ST_CAL;
			end
			ST_CAL: begin
				cal_d   = 1'b1;
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		// Power-on waits for the supply to settle before loading the bits.
		if (pwr_d && !pwr_q) begin
			pon_d = PON_CYCLES;
		end else if (pon_q != 8'h00) begin
			pon_d = pon_q - 8'h01;
		end
		if (pon_fire) begin
			out_d = held_q;
		end
		// The bits are never floated, so an unpowered spectrometer must see zeros.
		if (!pwr_q) begin
			out_d = 4'h0;
			pon_d = (pwr_d) ? PON_CYCLES : 8'h00;
		end
	end

	// Wishbone classic slave: ack one cycle after the strobe, write lands on the ack edge.
	assign wb_req  = wb_i.cyc && wb_i.stb;
	assign wr_ctrl = wb_req && ack_q && wb_i.we && wb_i.sel[0] && (wb_i.adr == REG_CTRL);

	always_comb begin
		ack_d  = wb_req && !ack_q;
		pwr_d  = pwr_q;
		nacc_d = nacc_q + {7'h00, acc_q};
		nrej_d = nrej_q + {7'h00, rej_q};
		rdat_d = rdat_q;
		if (wr_ctrl) begin
			pwr_d = wb_i.dat[CTRL_PWR_BIT];
		end
		if (wb_req && !ack_q) begin
			case (wb_i.adr)
				REG_CTRL:   rdat_d = {31'h0, pwr_q};
				REG_STATUS: rdat_d = {20'h0, tc_ready_o, state_q, pwr_q, out_q, held_q};
				REG_CWORD:  rdat_d = {4'h0, CTRL_WORD_LOC, ctrl_word_o};
				REG_RBACK:  rdat_d = {16'h0, readback_o};
				REG_COUNT:  rdat_d = {16'h0, nrej_q, nacc_q};
				default:    rdat_d = 32'h0;
			endcase
		end
	end

	// Register stage; reset starts with the spectrometer off.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			idx_q   <= 3'h0;
			bad_q   <= 1'b0;
			val_q   <= 4'h0;
			held_q  <= HELD_RESET;
			out_q   <= 4'h0;
			pwr_q   <= 1'b0;
			pon_q   <= 8'h00;
			cal_q   <= 1'b0;
			acc_q   <= 1'b0;
			rej_q   <= 1'b0;
			nacc_q  <= 8'h00;
			nrej_q  <= 8'h00;
			ack_q   <= 1'b0;
			rdat_q  <= 32'h0;
		end else begin
			state_q <= state_d;
			idx_q   <= idx_d;
			bad_q   <= bad_d;
			val_q   <= val_d;
			held_q  <= held_d;
			out_q   <= out_d;
			pwr_q   <= pwr_d;
			pon_q   <= pon_d;
			cal_q   <= cal_d;
			acc_q   <= acc_d;
			rej_q   <= rej_d;
			nacc_q  <= nacc_d;
			nrej_q  <= nrej_d;
			ack_q   <= ack_d;
			rdat_q  <= rdat_d;
		end
	end

	// Scattered placement of the attenuation bits; a value n reads as n dB down.
	always_comb begin
		ctrl_word_o        = 16'h0000;
		ctrl_word_o[CW_B0] = out_q[0];
		ctrl_word_o[CW_B1] = out_q[1];
		ctrl_word_o[CW_B2] = out_q[2];
		ctrl_word_o[CW_B3] = out_q[3];
		readback_o         = 16'h0000;
		readback_o[RB_B0]  = ctrl_word_o[CW_B0];
		readback_o[RB_B1]  = ctrl_word_o[CW_B1];
		readback_o[RB_B2]  = ctrl_word_o[CW_B2];
		readback_o[RB_B3]  = ctrl_word_o[CW_B3];
	end

	assign atten_o        = out_q;
	assign shutdown_req_o = (state_q == ST_SHUT);
	assign cal_start_o    = cal_q;
	assign accept_o       = acc_q;
	assign reject_o       = rej_q;
	assign wb_o           = '{ack: ack_q, dat: rdat_q};

	// Checks on the sequencing and the output bits.
	localparam int A_PON_MAX = 40;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_reset_vals;
		$past(rst_i) |-> (held_q == HELD_RESET) && (out_q == 4'h0);
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

	property p_off_zero;
		!pwr_q |=> (out_q == 4'h0);
	endproperty
	a_off_zero: assert property (p_off_zero) else $error("bits not zero while off");

	property p_mode_change;
		good && pwr_q |=> shutdown_req_o && !tc_ready_o;
	endproperty
	a_mode_change: assert property (p_mode_change) else $error("no mode change");

	property p_apply_then_cal;
		shutdown_req_o && shutdown_done_i && pwr_q ##1 pwr_q |=> (out_q == held_q) ##1 cal_start_o;
	endproperty
	a_apply_then_cal: assert property (p_apply_then_cal) else $error("apply or calibration order wrong");

	property p_power_on_load;
		$rose(pwr_q) ##1 pwr_q[*8] |-> ##[1:A_PON_MAX] (out_q == held_q) || !pwr_q;
	endproperty
	a_power_on_load: assert property (p_power_on_load) else $error("setting not loaded after power on");

	property p_held_on_good;
		good && !pon_fire && (state_q == ST_IDLE) && (pwr_q || (out_q == 4'h0))
			|=> (held_q == $past(val_q)) && (out_q == $past(out_q));
	endproperty
	a_held_on_good: assert property (p_held_on_good) else $error("held value not stored alone");

	property p_drop_bad;
		take && tc_i.last && !good |=> $stable(held_q) && reject_o && !accept_o;
	endproperty
	a_drop_bad: assert property (p_drop_bad) else $error("bad packet changed state");

	property p_big_value;
		take && !tc_i.last && (idx_q == 3'h5) && (tc_i.data[15:4] != 12'h000) |=> bad_q;
	endproperty
	a_big_value: assert property (p_big_value) else $error("large value not flagged");

	property p_cal_off;
		good && !pwr_q |=> cal_start_o;
	endproperty
	a_cal_off: assert property (p_cal_off) else $error("no calibration start");

	property p_readback;
		(readback_o[9] == out_q[0]) && (readback_o[8] == out_q[1]) && (readback_o[2] == out_q[2])
			&& (readback_o[1] == out_q[3]);
	endproperty
	a_readback: assert property (p_readback) else $error("readback mapping wrong");

	property p_wb_ack;
		wb_req && !ack_q |=> ack_q ##1 !ack_q;
	endproperty
	a_wb_ack: assert property (p_wb_ack) else $error("bus ack timing wrong");

	c_accept_powered: cover property (good && pwr_q ##[1:20] cal_start_o);
	c_reject: cover property (reject_o);
	c_power_on_load: cover property (pon_fire && (held_q != 4'h0));
endmodule
`default_nettype wire

// ===== testbench/ifph_tc_model.sv
// Telecommand source that stands in for the spacecraft uplink path.
// Assumes the handler takes a word at each rising edge where valid and ready are both high.
`timescale 1ns/1ns
`default_nettype none
module ifph_tc_model (
	input  wire logic          clk_i,
	input  wire logic          ready_i,
	output var ifph_pkg::ifph_tc_t tc_o
);
	import ifph_pkg::*;

	logic [10:0] seq_q = 11'h000;
	// Words that were pushed on without ever seeing ready; the bench expects none.
	int          stalls = 0;

	initial tc_o = '0;

	// One checksum step over a word, MSB first; written apart from the design on purpose.
	function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [15:0] d);
		logic fb;
		for (int b = 15; b >= 0; b--) begin
			fb = c[15] ^ d[b];
			c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
		end
		return c;
	endfunction

	// Sends one whole packet; bad names the word to spoil, or -1 for none.
	// The packet checksum is worked out after spoiling, so only word 6 tests it.
	task automatic send(input logic [15:0] val, input int bad);
		logic [15:0] w [7];
		logic [15:0] c;
		int          n;
		w[0] = {3'h0, 1'h1, 1'h1, 7'h47, 4'hC};
		w[1] = {2'h3, 3'h0, seq_q};
		w[2] = 16'h0007;
		w[3] = {3'h0, 1'h1, 4'h1, 8'hC0};
		w[4] = {8'h04, 8'h00};
		w[5] = val;
		c = CRC_INIT;
		for (int i = 0; i < 6; i++) begin
			if (i == bad) w[i] = w[i] ^ 16'h8000;
			c = crc_word(c, w[i]);
		end
		w[6] = (bad == 6) ? ~c : c;
		seq_q = seq_q + 11'h001;
		@(posedge clk_i);
		for (int i = 0; i < 7; i++) begin
			tc_o <= '{1'b1, i == 6, w[i]};
			n = 0;
			// Ready is looked at mid-cycle; the next rising edge then takes the word.
			do begin
				@(negedge clk_i);
				n++;
			end while (ready_i !== 1'b1 && n < 200);
			if (ready_i !== 1'b1) stalls++;
			@(posedge clk_i);
		end
		// Released data shows the inverse so a stale word is never mistaken for a live one.
		tc_o <= '{1'b0, 1'b0, ~w[6]};
	endtask
endmodule
`default_nettype wire

// ===== testbench/if_power_telecommand_handler_test.sv
// Self-checking bench for the attenuation telecommand handler.
// Assumes the telecommand source model and the handler with a short power-on delay.
`timescale 1ns/1ns
`default_nettype none
module if_power_telecommand_handler_test;
	import ifph_pkg::*;

	typedef struct packed {
		logic [15:0] val;
		logic [15:0] cw;
		logic [15:0] rb;
	} ifph_row_t;

	logic         clk_i;
	logic         rst_i;
	logic         shutdown_done_i;
	ifph_tc_t     tc_i;
	logic         tc_ready_o;
	logic         shutdown_req_o;
	logic         cal_start_o;
	logic         accept_o;
	logic         reject_o;
	logic [3:0]   atten_o;
	logic [15:0]  ctrl_word_o;
	logic [15:0]  readback_o;
	ifph_wb_req_t wb_i;
	ifph_wb_rsp_t wb_o;
	logic [31:0]  rd;
	int           miscompares = 0;
	int           cmp_count = 0;
	// The first four rows walk one setting bit, then all bits and none, with the control and readback words each must give.
	ifph_row_t    rows [6] = '{'{16'h0001, 16'h0040, 16'h0200}, '{16'h0002, 16'h0080, 16'h0100},
		'{16'h0004, 16'h2000, 16'h0004}, '{16'h0008, 16'h4000, 16'h0002},
		'{16'h000F, 16'h60C0, 16'h0306}, '{16'h0000, 16'h0000, 16'h0000}};

	ifph_handler #(.PON_CYCLES(8'h03)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .tc_i(tc_i),
		.tc_ready_o(tc_ready_o), .shutdown_done_i(shutdown_done_i), .shutdown_req_o(shutdown_req_o),
		.cal_start_o(cal_start_o), .accept_o(accept_o), .reject_o(reject_o), .atten_o(atten_o),
		.ctrl_word_o(ctrl_word_o), .readback_o(readback_o), .wb_i(wb_i), .wb_o(wb_o));
	ifph_tc_model src_u (.clk_i(clk_i), .ready_i(tc_ready_o), .tc_o(tc_i));

	// Free-running 20 MHz clock.
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic hit(input int w);
		case (w)
			0: return wb_o.ack === 1'b1;
			1: return (accept_o | reject_o) === 1'b1;
			2: return cal_start_o === 1'b1;
			default: return atten_o !== 4'h0;
		endcase
	endfunction

	// Bounded wait at mid-cycle; a wait that runs out ends the run as a failure.
	task automatic await(input int w);
		int n;
		n = 0;
		@(negedge clk_i);
		while (!hit(w) && n < 100) begin
			@(negedge clk_i);
			n++;
		end
		if (n >= 100) begin
			miscompares++;
			wrap_up();
		end
	endtask

	// Classic single Wishbone cycle, held until ack, then released for a cycle.
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge clk_i);
		wb_i <= '{1'b1, 1'b1, we, adr, 4'hF, dat};
		await(0);
		// Read data is taken at the edge where ack is seen high, then the request is released.
		@(posedge clk_i);
		rd = wb_o.dat;
		wb_i <= '0;
	endtask

	task automatic tc_send(input logic [15:0] v, input int bad, input logic ok);
		src_u.send(v, bad);
		await(1);
		check("accept", accept_o, ok);
		check("reject", reject_o, !ok);
	endtask

	// A command while powered must go through shutdown before the outputs move.
	task automatic pw_send(input ifph_row_t r);
		logic [3:0] a0;
		a0 = atten_o;
		tc_send(r.val, -1, 1'b1);
		check("shutdown", shutdown_req_o, 1'b1);
		check("ready", tc_ready_o, 1'b0);
		check("early", atten_o, a0);
		@(posedge clk_i);
		shutdown_done_i <= 1'b1;
		@(posedge clk_i);
		shutdown_done_i <= 1'b0;
		await(2);
		check("atten", atten_o, r.val[3:0]);
		check("cword", ctrl_word_o, r.cw);
		check("rback", readback_o, r.rb);
	endtask

	// Main sequence: reset, refusals while off, power-on load, powered commands, power-off.
	initial begin
		rst_i = 1'b1;
		shutdown_done_i = 1'b0;
		wb_i = '0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		check("atten", atten_o, 4'h0);
		check("cword", ctrl_word_o, 16'h0000);
		wb(1'b0, REG_STATUS, 32'h0);
		check("status", rd[8:0], 9'h003);
		for (int b = 0; b < 7; b++) tc_send(16'h0001, b, 1'b0);
		tc_send(16'h0010, -1, 1'b0);
		tc_send(16'h0009, -1, 1'b1);
		check("cal", cal_start_o, 1'b1);
		check("atten", atten_o, 4'h0);
		wb(1'b0, REG_COUNT, 32'h0);
		check("count", rd[15:0], 16'h0801);
		wb(1'b0, REG_STATUS, 32'h0);
		check("held", rd[3:0], 4'h9);
		wb(1'b1, REG_CTRL, 32'h1);
		await(3);
		check("atten", atten_o, 4'h9);
		check("cword", ctrl_word_o, 16'h4040);
		check("rback", readback_o, 16'h0202);
		wb(1'b0, REG_CWORD, 32'h0);
		check("cwreg", rd, {4'h0, CTRL_WORD_LOC, 16'h4040});
		wb(1'b0, REG_RBACK, 32'h0);
		check("rbreg", rd, 32'h00000202);
		for (int i = 0; i < 6; i++) pw_send(rows[i]);
		wb(1'b0, 8'h20, 32'h0);
		check("unmapped", rd, 32'h0);
		pw_send(rows[4]);
		wb(1'b1, REG_CTRL, 32'h0);
		repeat (2) @(negedge clk_i);
		check("atten", atten_o, 4'h0);
		check("cword", ctrl_word_o, 16'h0000);
		check("rback", readback_o, 16'h0000);
		// Power back on reloads the held value; a restart then must clear the bits and restore 3.
		wb(1'b1, REG_CTRL, 32'h1);
		await(3);
		check("atten", atten_o, 4'hF);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		check("atten", atten_o, 4'h0);
		check("cword", ctrl_word_o, 16'h0000);
		wb(1'b0, REG_STATUS, 32'h0);
		check("status", rd[8:0], 9'h003);
		check("stalls", src_u.stalls, 32'h0);
		wrap_up();
	end
endmodule
`default_nettype wire
